/* verilog/fir_pkg.sv */
// Behaviour
// - input samples are signed, 4..27 bits wide (asymmetric) or 4..26 (symmetric).
// - the tap count is 3..96 (asymmetric) or 6..192 (symmetric).
// - asymmetric filters give every tap its own coefficient and multiply.
// - symmetric filters fold the delay line so one coefficient serves two taps.
// - symmetric pre-adders sum the two folded samples with one bit of growth.
// - the pre-adder pipeline option adds a flop after the pre-adder.
// - the multiplier pipeline option adds a flop after each multiplier.
// - asymmetric-response mode turns the folded pre-adders into subtracters.
// - each tap coefficient is a signed 18-bit value fed to the A operand.
package fir_pkg;
    // =========================================================
    // arithmetic limits
    localparam int COEF_W        = 18;
    localparam int DW_MIN        = 4;
    localparam int DW_MAX_ASYM   = 27;
    localparam int DW_MAX_SYM    = 26;
    localparam int TAPS_MIN_ASYM = 3;
    localparam int TAPS_MAX_ASYM = 96;
    localparam int TAPS_MIN_SYM  = 6;
    localparam int TAPS_MAX_SYM  = 192;
    localparam int FIFO_DEPTH    = 8;
    localparam int CLK_PERIOD_NS = 4;

    // =========================================================
    // register map
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_STATUS   = 12'h004;
    localparam logic [11:0] REG_COUNT    = 12'h008;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_CLR_BIT = 1;
    localparam logic        CTRL_EN_RST  = 1'h1;
    localparam int          ST_EN_BIT    = 0;
    localparam int          ST_FULL_BIT  = 1;
    localparam int          ST_PEND_BIT  = 2;
    localparam int          ST_LVL_LSB   = 4;

    // status word fields
    typedef struct packed {
        logic [3:0] level;
        logic       pend;
        logic       full;
        logic       en;
    } status_t;
endpackage : fir_pkg

/* verilog/fir_filter.sv */
`timescale 1ns/10ps

// =============================================================
// result fifo
module fir_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o,
    output logic [$clog2(D):0] level_o
);
    localparam int PW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [PW:0]         cnt;
    } fifo_st_t;

    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic     wr;
    logic     rd;

    // honest flags straight from the count
    assign in_ready_o  = (st_ff.cnt != (PW+1)'(D));
    assign out_valid_o = (st_ff.cnt != '0);
    assign out_data_o  = st_ff.mem[st_ff.rp];
    assign level_o     = st_ff.cnt;
    assign wr          = in_valid_i && in_ready_o;
    assign rd          = out_valid_o && out_ready_i;

    // pointer wrap works for any depth, not only powers of two
    always_comb begin
        nxt_st = st_ff;
        if (wr) begin
            nxt_st.mem[st_ff.wp] = in_data_i;
            nxt_st.wp = (st_ff.wp == PW'(D-1)) ? '0 : st_ff.wp + 1'b1;
        end
        if (rd) begin
            nxt_st.rp = (st_ff.rp == PW'(D-1)) ? '0 : st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (PW+1)'(wr) - (PW+1)'(rd);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : fir_fifo

// =============================================================
// fir filter top
module fir_filter
    import fir_pkg::*;
#(
    parameter int   DW        = 16,
    parameter int   NTAPS     = 8,
    parameter bit   SYMMETRIC = 1'b0,
    parameter bit   ASYM_RESP = 1'b0,
    parameter bit   PRE_PIPE  = 1'b0,
    parameter bit   MUL_PIPE  = 1'b0,
    parameter int   NMUL      = SYMMETRIC ? NTAPS / 2 : NTAPS,
    parameter int   OW        = DW + 1 + COEF_W + $clog2(NMUL),
    parameter logic [NTAPS-1:0][COEF_W-1:0] COEF =
        {NTAPS{COEF_W'(1)}}
) (
    input  wire logic          mclk_i,
    input  wire logic          reset_n_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [11:0]   paddr_i,
    input  wire logic [31:0]   pwdata_i,
    input  wire logic [3:0]    pstrb_i,
    output logic [31:0]        prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic          s_valid_i,
    output logic               s_ready_o,
    input  wire logic [DW-1:0] s_data_i,
    output logic               m_valid_o,
    input  wire logic          m_ready_i,
    output logic [OW-1:0]      m_data_o
);
    localparam int PW = DW + 1;
    localparam int MW = PW + COEF_W;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        logic                      en;
        logic [31:0]               cnt;
        logic                      ack;
        logic [31:0]               rdata;
        logic [NTAPS-1:0][DW-1:0]  dly;
        logic [NMUL-1:0][PW-1:0]   pre;
        logic [NMUL-1:0][MW-1:0]   prod;
        logic [OW-1:0]             acc;
        logic                      v_dly;
        logic                      v_pre;
        logic                      v_mul;
        logic                      v_out;
    } top_st_t;

    top_st_t                 st_ff;
    top_st_t                 nxt_st;
    logic [1:0]              rst_sync_ff;
    logic                    rst_n;
    logic                    move;
    logic                    accept;
    logic                    f_ready;
    logic [LW-1:0]           f_level;
    logic                    mapped;
    logic                    wr_req;
    logic [NMUL-1:0][PW-1:0] pre_c;
    logic [NMUL-1:0][PW-1:0] pre_u;
    logic [NMUL-1:0][MW-1:0] prod_c;
    logic [NMUL-1:0][MW-1:0] prod_u;
    logic [OW-1:0]           sum_c;
    logic                    v_pre_u;
    logic                    v_mul_u;
    status_t                 stat;

    // =========================================================
    // reset release: async assert, two-flop release
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // =========================================================
    // stream handshake: whole pipe stalls when the fifo backs up
    assign move      = !st_ff.v_out || f_ready;
    assign s_ready_o = st_ff.en && move;
    assign accept    = s_valid_i && s_ready_o;

    // =========================================================
    // arithmetic datapath
    always_comb begin
        sum_c = '0;
        for (int i = 0; i < NMUL; i++) begin
            if (SYMMETRIC) begin
                // folded pair, one bit of growth
                if (ASYM_RESP) begin
                    pre_c[i] = PW'($signed(st_ff.dly[i]))
                             - PW'($signed(st_ff.dly[NTAPS-1-i]));
                end else begin
                    pre_c[i] = PW'($signed(st_ff.dly[i]))
                             + PW'($signed(st_ff.dly[NTAPS-1-i]));
                end
            end else begin
                pre_c[i] = PW'($signed(st_ff.dly[i]));
            end
            pre_u[i]  = PRE_PIPE ? st_ff.pre[i] : pre_c[i];
            prod_c[i] = MW'($signed(pre_u[i]) * $signed(COEF[i]));
            prod_u[i] = MUL_PIPE ? st_ff.prod[i] : prod_c[i];
            sum_c     = sum_c + OW'($signed(prod_u[i]));
        end
    end

    assign v_pre_u = PRE_PIPE ? st_ff.v_pre : st_ff.v_dly;
    assign v_mul_u = MUL_PIPE ? st_ff.v_mul : v_pre_u;

    // =========================================================
    // apb decode; answer one cycle into the access phase
    assign mapped = (paddr_i == REG_CTRL) || (paddr_i == REG_STATUS)
                 || (paddr_i == REG_COUNT);
    assign wr_req = psel_i && penable_i && st_ff.ack && pwrite_i;
    assign pready_o  = st_ff.ack;
    assign pslverr_o = st_ff.ack && !mapped;
    assign prdata_o  = st_ff.rdata;
    assign stat.en    = st_ff.en;
    assign stat.full  = !f_ready;
    assign stat.pend  = st_ff.v_dly || st_ff.v_pre || st_ff.v_mul
                     || st_ff.v_out;
    assign stat.level = 4'(f_level);

    // =========================================================
    // next state
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = psel_i && penable_i && !st_ff.ack;
        if (psel_i && penable_i && !st_ff.ack && !pwrite_i) begin
            unique case (paddr_i)
                REG_CTRL:   nxt_st.rdata = 32'(st_ff.en);
                REG_STATUS: begin
                    // fields go to their map positions, not packed order
                    nxt_st.rdata                  = 32'h0;
                    nxt_st.rdata[ST_EN_BIT]       = stat.en;
                    nxt_st.rdata[ST_FULL_BIT]     = stat.full;
                    nxt_st.rdata[ST_PEND_BIT]     = stat.pend;
                    nxt_st.rdata[ST_LVL_LSB +: 4] = stat.level;
                end
                REG_COUNT:  nxt_st.rdata = st_ff.cnt;
                default:    nxt_st.rdata = 32'h0;
            endcase
        end
        // write lands only on the edge that sees pready high
        if (wr_req && mapped && pstrb_i[0] && paddr_i == REG_CTRL) begin
            nxt_st.en = pwdata_i[CTRL_EN_BIT];
            if (pwdata_i[CTRL_CLR_BIT]) begin
                nxt_st.cnt = 32'h0;
            end
        end
        // a result leaving in the clear cycle still counts
        if (st_ff.v_out && f_ready) begin
            nxt_st.cnt = nxt_st.cnt + 32'h1;
        end
        // delay line shifts only on accepted samples
        if (accept) begin
            nxt_st.dly = {st_ff.dly[NTAPS-2:0], s_data_i};
        end
        if (move) begin
            nxt_st.v_dly = accept;
            nxt_st.pre   = pre_c;
            nxt_st.v_pre = st_ff.v_dly;
            nxt_st.prod  = prod_c;
            nxt_st.v_mul = v_pre_u;
            nxt_st.acc   = sum_c;
            nxt_st.v_out = v_mul_u;
        end
    end

    // config is parameter-only, so no config flops; these hold the register and pipe state
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff    <= '0;
            st_ff.en <= CTRL_EN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // output buffering
    fir_fifo #(
        .W (OW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (st_ff.v_out),
        .in_ready_o  (f_ready),
        .in_data_i   (st_ff.acc),
        .out_valid_o (m_valid_o),
        .out_ready_i (m_ready_i),
        .out_data_o  (m_data_o),
        .level_o     (f_level)
    );

    // =========================================================
    // checks
    logic [3:0] inflight_ff;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            inflight_ff <= 4'h0;
        end else begin
            inflight_ff <= inflight_ff + 4'(accept)
                         - 4'(st_ff.v_out && f_ready);
        end
    end

    AST_DW_RANGE: assert property (@(posedge mclk_i)
        DW >= DW_MIN && DW <= (SYMMETRIC ? DW_MAX_SYM : DW_MAX_ASYM))
        else $error("sample width out of range");
    AST_TAP_RANGE: assert property (@(posedge mclk_i)
        SYMMETRIC ? (NTAPS >= TAPS_MIN_SYM && NTAPS <= TAPS_MAX_SYM)
                  : (NTAPS >= TAPS_MIN_ASYM && NTAPS <= TAPS_MAX_ASYM))
        else $error("tap count out of range");
    AST_DLY_SHIFT: assert property (@(posedge mclk_i) disable iff (!rst_n)
        accept |=> st_ff.dly[0] == $past(s_data_i)
            && st_ff.dly[1] == $past(st_ff.dly[0]))
        else $error("delay line did not shift");
    AST_FOLD: assert property (@(posedge mclk_i) disable iff (!rst_n)
        SYMMETRIC && !ASYM_RESP |-> $signed(pre_c[0]) ==
            $signed(st_ff.dly[0]) + $signed(st_ff.dly[NTAPS-1]))
        else $error("folded pre-add wrong");
    AST_PRESUB: assert property (@(posedge mclk_i) disable iff (!rst_n)
        SYMMETRIC && ASYM_RESP |-> $signed(pre_c[0]) ==
            $signed(st_ff.dly[0]) - $signed(st_ff.dly[NTAPS-1]))
        else $error("pre-subtract wrong");
    AST_PRE_FLOP: assert property (@(posedge mclk_i) disable iff (!rst_n)
        PRE_PIPE && move |=> pre_u == $past(pre_c))
        else $error("pre-adder flop missing");
    AST_MUL_FLOP: assert property (@(posedge mclk_i) disable iff (!rst_n)
        MUL_PIPE && move |=> prod_u == $past(prod_c))
        else $error("multiplier flop missing");
    AST_COEF_A: assert property (@(posedge mclk_i) disable iff (!rst_n)
        $signed(prod_c[NMUL-1]) ==
            $signed(pre_u[NMUL-1]) * $signed(COEF[NMUL-1]))
        else $error("coefficient not on A operand");
    AST_ONE_OUT: assert property (@(posedge mclk_i) disable iff (!rst_n)
        inflight_ff <= 4'h4)
        else $error("outputs do not match inputs");
    AST_NO_PIPE_LAT: assert property (@(posedge mclk_i) disable iff (!rst_n)
        !PRE_PIPE && !MUL_PIPE && accept && move |=>
            move |=> st_ff.v_out)
        else $error("latency wrong");
    AST_CFG_FIXED: assert property (@(posedge mclk_i) disable iff (!rst_n)
        $stable(COEF) && $stable(SYMMETRIC))
        else $error("configuration changed");

    COV_ACCEPT: cover property (@(posedge mclk_i) accept ##1 accept);
    COV_FULL: cover property (@(posedge mclk_i) !f_ready && s_valid_i);
    COV_WRITE: cover property (@(posedge mclk_i) wr_req);
endmodule : fir_filter

/* sim/fir_sink.sv */
`timescale 1ns/10ps

// =====================================================
// downstream result consumer
module fir_sink #(
    parameter int OW = 8
) (
    input  wire logic          mclk_i,
    input  wire logic          stall_i,
    input  wire logic          m_valid_i,
    input  wire logic [OW-1:0] m_data_i,
    output logic               m_ready_o
);
    logic [63:0] got[$];

    initial m_ready_o = 1'b1;
    // registered ready, so a stall lands one edge late
    always @(posedge mclk_i) begin
        m_ready_o <= !stall_i;
    end
    // capture mid-cycle to stay clear of edge-time updates
    always @(negedge mclk_i) begin
        if (m_valid_i === 1'b1 && m_ready_o) begin
            got.push_back(64'(signed'(m_data_i)));
        end
    end
endmodule : fir_sink

/* sim/tb_configurable_fir_filter.sv */
`timescale 1ns/10ps

// =====================================================
// bench top
module tb_configurable_fir_filter;
    import fir_pkg::*;
    localparam int DWT = 8;
    localparam int NT = 6;
    localparam int OW = DWT + 1 + COEF_W + 2;
    localparam logic [5:0][17:0] CF = {54'h0, 18'h3ffff, 18'h2, 18'h1};
    localparam logic [7:0] PAT [9] = '{8'h80, 8'h7f, 8'h01, 8'hff, 8'h00,
                                       8'h7f, 8'h80, 8'h7f, 8'h2a};
    logic          mclk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [3:0]    pstrb;
    logic [31:0]   pwdata, prdata;
    logic          s_valid, s_ready, m_valid, m_ready, stall;
    logic [7:0]    s_data;
    logic [OW-1:0] m_data;
    int            miscompares, n_tests, pi, ck, nb;
    int            hist[$];

    fir_filter #(.DW(DWT), .NTAPS(NT), .SYMMETRIC(1'b1),
        .ASYM_RESP(1'b1), .PRE_PIPE(1'b1), .MUL_PIPE(1'b1), .COEF(CF))
    DUT (.mclk_i(mclk), .reset_n_i(reset_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .s_valid_i(s_valid),
        .s_ready_o(s_ready), .s_data_i(s_data), .m_valid_o(m_valid),
        .m_ready_i(m_ready), .m_data_o(m_data));
    fir_sink #(.OW(OW)) u_sink (.mclk_i(mclk), .stall_i(stall),
        .m_valid_i(m_valid), .m_data_i(m_data), .m_ready_o(m_ready));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // one apb transfer; answer taken at the rising edge that sees pready
    // no cycle count assumed: only the watchdog ends a hung wait
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp,
                          input logic eerr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        check(64'(rd), 64'(exp));
        check(64'(er), 64'(eerr));
    endtask : reg_rd

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, wd, rd, er);
    endtask : reg_wr

    // offer n samples; gives up after 8 refused cycles in a row
    task automatic push(input int n);
        int idle;
        logic took;
        idle = 0;
        s_valid <= 1'b1; s_data <= PAT[pi % 9];
        while (n > 0 && idle < 8) begin
            @(negedge mclk);
            took = (s_ready === 1'b1);
            @(posedge mclk);
            if (took) begin
                hist.push_back(int'(signed'(PAT[pi % 9])));
                pi++; n--; idle = 0;
                s_data <= PAT[pi % 9];
            end else begin
                idle++;
            end
        end
        s_valid <= 1'b0;
    endtask : push

    function automatic longint xs(input int k);
        return (k < 0) ? 0 : longint'(hist[k]);
    endfunction : xs

    // folded taps, second operand subtracted
    function automatic longint expect_at(input int n);
        longint s;
        s = 0;
        for (int i = 0; i < 3; i++)
            s += longint'(signed'(CF[i])) * (xs(n - i) - xs(n - 5 + i));
        return s;
    endfunction : expect_at

    task automatic drain();
        int w;
        stall <= 1'b0; w = 0;
        while (u_sink.got.size() < hist.size() && w < 200) begin
            @(posedge mclk); w++;
        end
        check(64'(u_sink.got.size()), 64'(hist.size()));
        for (; ck < u_sink.got.size(); ck++)
            check(u_sink.got[ck], 64'(expect_at(ck)));
    endtask : drain

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        results();
    end

    initial begin
        int lat;
        reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; s_valid = 1'b0;
        s_data = 8'h00; stall = 1'b0; pstrb = 4'hf;
        miscompares = 0; n_tests = 0; pi = 0; ck = 0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        reg_rd(REG_CTRL, 32'h1, 1'b0);
        reg_rd(REG_STATUS, 32'h1, 1'b0);
        reg_rd(REG_COUNT, 32'h0, 1'b0);
        reg_rd(12'h00c, 32'h0, 1'b1);
        // a write without byte lane 0 must leave the enable alone
        pstrb <= 4'h0;
        reg_wr(REG_CTRL, 32'h0);
        reg_rd(REG_CTRL, 32'h1, 1'b0);
        pstrb <= 4'hf;
        // latency with both pipe flops present
        push(1);
        lat = 0;
        do begin
            @(negedge mclk);
            lat++;
        end while (m_valid !== 1'b1 && lat < 50);
        check(64'(lat), 64'd5);
        @(posedge mclk);
        push(8);
        drain();
        // stall the consumer until the buffer refuses
        stall <= 1'b1;
        push(40);
        reg_rd(REG_STATUS, 32'h87, 1'b0);
        drain();
        reg_rd(REG_COUNT, 32'(hist.size()), 1'b0);
        reg_wr(REG_CTRL, 32'h0);
        nb = hist.size();
        push(1);
        check(64'(hist.size()), 64'(nb));
        reg_rd(REG_STATUS, 32'h0, 1'b0);
        reg_wr(REG_CTRL, 32'h3);
        reg_rd(REG_COUNT, 32'h0, 1'b0);
        push(3);
        drain();
        reg_rd(REG_COUNT, 32'h3, 1'b0);
        results();
    end
endmodule : tb_configurable_fir_filter
